//--- rtl/pmc_map.svh
/*
  Offsets, field positions, reset values and codes of the configuration
  bank. Assumes it is included once per compile unit by its bare name.
*/
// What this block does
// R1: low timing word 0x4000 means 8 ms bursts, 0x1A80 means 16 ms.
// R2: high timing word 0x0003 means 8 ms bursts, 0x0006 means 16 ms.
// R3: host writes matching low/high codes, only the listed ones.
// R4: after reset low word is 0x4000 and high word 0x0003.
// R5: link-up register: field bits 3:1 reset 100, rsvd 8:4 and bit 0.
// R6: led style override, bit 4 of common control, always reads zero.
// R7: override write sets status bit 3; status loads from strap at reset.
// R8: led style 1 means single led, 0 means tri-color dual led.
// R9: common control bits 15:5 and bit 2 are rw, reset to zero.
// R10: registers reached only indirectly through the portal.
// R11: link-up code is stored and read back as written.
`ifndef PMC_MAP_SVH
`define PMC_MAP_SVH

`define PMC_DEV_AN 5'h00
`define PMC_DEV_PMA 5'h01
`define PMC_DEV_VEND 5'h02

`define PMC_REG_FLP_LO 16'h0003
`define PMC_REG_FLP_HI 16'h0004
`define PMC_REG_LINK_UP 16'h005a
`define PMC_REG_COMMON 16'h0000

`define PMC_FLP_LO_8MS 16'h4000
`define PMC_FLP_LO_16MS 16'h1a80
`define PMC_FLP_HI_8MS 16'h0003
`define PMC_FLP_HI_16MS 16'h0006

`define PMC_LINK_RST 9'h108
`define PMC_LINK_FIELD_LSB 1
`define PMC_LINK_FIELD_MSB 3
`define PMC_LINK_MSB 8

`define PMC_CC_OVR_BIT 4
`define PMC_CC_STAT_BIT 3
`define PMC_CC_RSVD2_BIT 2
`define PMC_CC_HI_LSB 5
`define PMC_CC_HI_RST 11'h000

`endif

//--- rtl/pmc_pkg.sv
/*
  Types of the configuration bank.
  Assumes pmc_map.svh supplies the numeric constants.
*/
package pmc_pkg;
  typedef logic [15:0] pmc_word_t;
  typedef logic [4:0] pmc_dev_t;
endpackage : pmc_pkg

//--- rtl/pmc_config_bank.sv
/*
  Indirectly reached phy configuration bank: burst timing, link-up time,
  led style override. Assumes the portal logic presents one decoded
  device/register access per strobe, synchronous to i_clock.
*/
`timescale 1ns/1ps
`include "pmc_map.svh"

module pmc_config_bank (
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic i_led_style_strap,
  input wire pmc_pkg::pmc_dev_t i_mmd_dev,
  input wire pmc_pkg::pmc_word_t i_mmd_reg,
  input wire logic i_mmd_wr,
  input wire logic i_mmd_rd,
  input wire pmc_pkg::pmc_word_t i_mmd_wdata,
  output logic [15:0] o_mmd_rdata,
  output logic o_mmd_rvalid,
  output logic o_flp_16ms,
  output logic o_flp_mismatch,
  output logic [2:0] o_link_up_time,
  output logic o_led_single
);

  function automatic logic hit(input pmc_pkg::pmc_dev_t dev,
                               input pmc_pkg::pmc_word_t reg_a,
                               input pmc_pkg::pmc_dev_t want_dev,
                               input pmc_pkg::pmc_word_t want_reg);
    hit = (dev == want_dev) && (reg_a == want_reg);
  endfunction : hit

  pmc_pkg::pmc_word_t flp_lo_ff;
  pmc_pkg::pmc_word_t nxt_flp_lo;
  pmc_pkg::pmc_word_t flp_hi_ff;
  pmc_pkg::pmc_word_t nxt_flp_hi;
  logic [8:0] link_ff;
  logic [8:0] nxt_link;
  logic [10:0] cc_hi_ff;
  logic [10:0] nxt_cc_hi;
  logic cc_b2_ff;
  logic nxt_cc_b2;
  logic led_ff;
  logic nxt_led;
  logic [15:0] rdata_ff;
  logic [15:0] nxt_rdata;
  logic rvalid_ff;
  logic nxt_rvalid;
  logic flp16_ff;
  logic nxt_flp16;
  logic mism_ff;
  logic nxt_mism;
  logic sel_lo;
  logic sel_hi;
  logic sel_link;
  logic sel_cc;
  logic [15:0] rd_mux;

  // access decode
  always_comb begin
    sel_lo = hit(i_mmd_dev, i_mmd_reg, `PMC_DEV_AN, `PMC_REG_FLP_LO); // R10
    sel_hi = hit(i_mmd_dev, i_mmd_reg, `PMC_DEV_AN, `PMC_REG_FLP_HI);
    sel_link = hit(i_mmd_dev, i_mmd_reg, `PMC_DEV_PMA, `PMC_REG_LINK_UP);
    sel_cc = hit(i_mmd_dev, i_mmd_reg, `PMC_DEV_VEND, `PMC_REG_COMMON);
  end

  // register writes
  always_comb begin
    nxt_flp_lo = flp_lo_ff;
    nxt_flp_hi = flp_hi_ff;
    nxt_link = link_ff;
    nxt_cc_hi = cc_hi_ff;
    nxt_cc_b2 = cc_b2_ff;
    nxt_led = led_ff;
    if (i_srst) begin
      nxt_flp_lo = `PMC_FLP_LO_8MS; // R4
      nxt_flp_hi = `PMC_FLP_HI_8MS; // R4
      nxt_link = `PMC_LINK_RST; // R5
      nxt_cc_hi = `PMC_CC_HI_RST; // R9
      nxt_cc_b2 = 1'b0; // R9
      nxt_led = i_led_style_strap; // R7
    end else if (i_mmd_wr) begin
      if (sel_lo) begin
        nxt_flp_lo = i_mmd_wdata;
      end
      if (sel_hi) begin
        nxt_flp_hi = i_mmd_wdata;
      end
      if (sel_link) begin
        nxt_link = i_mmd_wdata[`PMC_LINK_MSB:0]; // R11
      end
      if (sel_cc) begin
        nxt_cc_hi = i_mmd_wdata[15:`PMC_CC_HI_LSB]; // R9
        nxt_cc_b2 = i_mmd_wdata[`PMC_CC_RSVD2_BIT]; // R9
        nxt_led = i_mmd_wdata[`PMC_CC_OVR_BIT]; // R7
      end
    end
  end

  always_ff @(posedge i_clock) begin
    flp_lo_ff <= nxt_flp_lo;
    flp_hi_ff <= nxt_flp_hi;
    link_ff <= nxt_link;
    cc_hi_ff <= nxt_cc_hi;
    cc_b2_ff <= nxt_cc_b2;
    led_ff <= nxt_led;
  end

  // read path and burst decode
  always_comb begin
    rd_mux = 16'h0000;
    if (sel_lo) begin
      rd_mux = flp_lo_ff;
    end else if (sel_hi) begin
      rd_mux = flp_hi_ff;
    end else if (sel_link) begin
      rd_mux = {7'h00, link_ff}; // R5
    end else if (sel_cc) begin
      // override bit reads zero, status shows led style
      rd_mux = {cc_hi_ff, 1'b0, led_ff, cc_b2_ff, 2'b00}; // R6
    end
    nxt_rdata = rdata_ff;
    nxt_rvalid = 1'b0;
    if (i_srst) begin
      nxt_rdata = 16'h0000;
    end else if (i_mmd_rd) begin
      nxt_rdata = rd_mux;
      nxt_rvalid = 1'b1;
    end
    nxt_flp16 = (flp_lo_ff == `PMC_FLP_LO_16MS) &&
                (flp_hi_ff == `PMC_FLP_HI_16MS); // R1
    nxt_mism = !nxt_flp16 && !((flp_lo_ff == `PMC_FLP_LO_8MS) &&
                (flp_hi_ff == `PMC_FLP_HI_8MS)); // R2
    if (i_srst) begin
      nxt_flp16 = 1'b0;
      nxt_mism = 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    rdata_ff <= nxt_rdata;
    rvalid_ff <= nxt_rvalid;
    flp16_ff <= nxt_flp16;
    mism_ff <= nxt_mism;
  end

  assign o_mmd_rdata = rdata_ff;
  assign o_mmd_rvalid = rvalid_ff;
  assign o_flp_16ms = flp16_ff;
  assign o_flp_mismatch = mism_ff; // R3
  assign o_link_up_time = link_ff[`PMC_LINK_FIELD_MSB:`PMC_LINK_FIELD_LSB];
  assign o_led_single = led_ff; // R8

  // checks
  sequence s_cc_wr;
    i_mmd_wr && !i_mmd_rd && sel_cc;
  endsequence

  sequence s_cc_rd;
    i_mmd_rd && !i_mmd_wr && sel_cc;
  endsequence

  property p_reset_flp;
    @(posedge i_clock) i_srst |=>
      (flp_lo_ff == 16'h4000) && (flp_hi_ff == 16'h0003);
  endproperty
  a_reset_flp: assert property (p_reset_flp) // R4
    else $error("burst timing words wrong after reset");

  property p_flp_16;
    @(posedge i_clock) disable iff (i_srst)
      (flp_lo_ff == 16'h1a80) && (flp_hi_ff == 16'h0006)
      |=> o_flp_16ms && !o_flp_mismatch;
  endproperty
  a_flp_16: assert property (p_flp_16) // R1
    else $error("16 ms burst codes not decoded");

  property p_flp_8;
    @(posedge i_clock) disable iff (i_srst)
      (flp_lo_ff == 16'h4000) && (flp_hi_ff == 16'h0003)
      |=> !o_flp_16ms && !o_flp_mismatch;
  endproperty
  a_flp_8: assert property (p_flp_8) // R2
    else $error("8 ms burst codes not decoded");

  property p_link_reset;
    @(posedge i_clock) i_srst ##1 !i_mmd_wr |=> (o_link_up_time == 3'h4);
  endproperty
  a_link_reset: assert property (p_link_reset) // R5
    else $error("link-up time field not at reset code");

  property p_ovr_reads_zero;
    @(posedge i_clock) disable iff (i_srst)
      s_cc_wr ##1 s_cc_rd |=> o_mmd_rvalid && !o_mmd_rdata[4] &&
        (o_mmd_rdata[3] == $past(i_mmd_wdata[4], 2));
  endproperty
  a_ovr_reads_zero: assert property (p_ovr_reads_zero) // R6
    else $error("override bit read back or status not updated");

  property p_led_update;
    @(posedge i_clock) disable iff (i_srst)
      i_mmd_wr && sel_cc |=> o_led_single == $past(i_mmd_wdata[4]);
  endproperty
  a_led_update: assert property (p_led_update) // R7
    else $error("led style not taken from override write");

  property p_strap;
    @(posedge i_clock) i_srst |=> o_led_single == $past(i_led_style_strap);
  endproperty
  a_strap: assert property (p_strap) // R7
    else $error("led style not loaded from strap");

  property p_cc_rsvd;
    @(posedge i_clock) disable iff (i_srst)
      s_cc_wr ##1 s_cc_rd |=>
        (o_mmd_rdata[15:5] == $past(i_mmd_wdata[15:5], 2)) &&
        (o_mmd_rdata[2] == $past(i_mmd_wdata[2], 2));
  endproperty
  a_cc_rsvd: assert property (p_cc_rsvd) // R9
    else $error("reserved common control bits not kept");

  property p_link_store;
    @(posedge i_clock) disable iff (i_srst)
      i_mmd_wr && sel_link |=>
        o_link_up_time == $past(i_mmd_wdata[3:1]);
  endproperty
  a_link_store: assert property (p_link_store) // R11
    else $error("link-up time code not stored");

  property p_rd_answer;
    @(posedge i_clock) disable iff (i_srst)
      i_mmd_rd |=> o_mmd_rvalid ##1 (o_mmd_rvalid == $past(i_mmd_rd));
  endproperty
  a_rd_answer: assert property (p_rd_answer) // R10
    else $error("read answer not one cycle after strobe");

endmodule : pmc_config_bank

//--- tb/pmc_host_model.sv
/*
  Host model of the portal side: one register access per xfer call, a write then a read per wrrd call.
  Assumes one bench process calls xfer, off the clock edge or on it.
*/
`timescale 1ns/1ps
module pmc_host_model (
  input wire logic i_clock,
  output pmc_pkg::pmc_dev_t o_dev,
  output pmc_pkg::pmc_word_t o_reg,
  output logic o_wr,
  output logic o_rd,
  output pmc_pkg::pmc_word_t o_wdata
);
  initial begin
    o_dev = 5'h00;
    o_reg = 16'h0000;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 16'h0000;
  end
  // one strobe cycle, then lines scrambled
  task automatic xfer(input logic w, input pmc_pkg::pmc_dev_t d,
                      input pmc_pkg::pmc_word_t r,
                      input pmc_pkg::pmc_word_t v);
    @(posedge i_clock);
    o_dev <= d;
    o_reg <= r;
    o_wr <= w;
    o_rd <= !w;
    o_wdata <= v;
    @(posedge i_clock);
    o_wr <= 1'b0;
    o_rd <= 1'b0;
    o_dev <= ~d;
    o_reg <= ~r;
    o_wdata <= ~v;
  endtask : xfer
  // write strobe, then read strobe of the same register next cycle
  task automatic wrrd(input pmc_pkg::pmc_dev_t d,
                      input pmc_pkg::pmc_word_t r,
                      input pmc_pkg::pmc_word_t v);
    @(posedge i_clock);
    o_dev <= d;
    o_reg <= r;
    o_wr <= 1'b1;
    o_rd <= 1'b0;
    o_wdata <= v;
    @(posedge i_clock);
    o_wr <= 1'b0;
    o_rd <= 1'b1;
    @(posedge i_clock);
    o_rd <= 1'b0;
    o_dev <= ~d;
    o_reg <= ~r;
    o_wdata <= ~v;
  endtask : wrrd
endmodule : pmc_host_model

//--- tb/test_pmc_config_bank.sv
/*
  Self-checking bench of the configuration bank.
  Assumes the host model drives the portal strobes.
*/
`timescale 1ns/1ps
`include "pmc_map.svh"
module test_pmc_config_bank;
  logic i_clock = 1'b0;
  logic i_srst = 1'b1;
  logic strap = 1'b1;
  pmc_pkg::pmc_dev_t dev;
  pmc_pkg::pmc_word_t rg, wd, rdata;
  logic wr, rd, rvalid, f16, mis, led;
  logic [2:0] lut;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;
  always #12.5 i_clock = ~i_clock;
  pmc_host_model host (.i_clock(i_clock), .o_dev(dev), .o_reg(rg),
    .o_wr(wr), .o_rd(rd), .o_wdata(wd));
  pmc_config_bank DUT (.i_clock(i_clock), .i_srst(i_srst),
    .i_led_style_strap(strap), .i_mmd_dev(dev), .i_mmd_reg(rg),
    .i_mmd_wr(wr), .i_mmd_rd(rd), .i_mmd_wdata(wd), .o_mmd_rdata(rdata),
    .o_mmd_rvalid(rvalid), .o_flp_16ms(f16), .o_flp_mismatch(mis),
    .o_link_up_time(lut), .o_led_single(led));
  task automatic chk(input string nm, input logic [15:0] s, e);
    tests_run++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic rdc(input pmc_pkg::pmc_dev_t d, input logic [15:0] r, e);
    host.xfer(1'b0, d, r, 16'h0000);
    #1;
    chk("rvalid", {15'h0, rvalid}, 16'h0001);
    chk("rdata", rdata, e);
  endtask : rdc
  task automatic wrw(input pmc_pkg::pmc_dev_t d, input logic [15:0] r, v);
    host.xfer(1'b1, d, r, v);
    @(posedge i_clock);
    #1;
  endtask : wrw
  task automatic flp(input logic [15:0] lo, hi, input logic e16, em);
    wrw(`PMC_DEV_AN, `PMC_REG_FLP_LO, lo);
    wrw(`PMC_DEV_AN, `PMC_REG_FLP_HI, hi);
    chk("flp16", {15'h0, f16}, {15'h0, e16});
    chk("mismatch", {15'h0, mis}, {15'h0, em});
  endtask : flp
  task automatic t_reset;
    #1;
    chk("flp16", {15'h0, f16}, 16'h0000);
    chk("lut", {13'h0, lut}, 16'h0004);
    chk("led", {15'h0, led}, 16'h0001);
    rdc(`PMC_DEV_AN, `PMC_REG_FLP_LO, 16'h4000);
    rdc(`PMC_DEV_AN, `PMC_REG_FLP_HI, 16'h0003);
    rdc(`PMC_DEV_PMA, `PMC_REG_LINK_UP, 16'h0108);
    rdc(`PMC_DEV_VEND, `PMC_REG_COMMON, 16'h0008);
  endtask : t_reset
  task automatic t_flp;
    flp(16'h1a80, 16'h0003, 1'b0, 1'b1);
    flp(16'h1a80, 16'h0006, 1'b1, 1'b0);
    flp(16'h4000, 16'h0003, 1'b0, 1'b0);
  endtask : t_flp
  task automatic t_link;
    wrw(`PMC_DEV_PMA, `PMC_REG_LINK_UP, 16'hffff);
    chk("lut", {13'h0, lut}, 16'h0007);
    rdc(`PMC_DEV_PMA, `PMC_REG_LINK_UP, 16'h01ff);
  endtask : t_link
  task automatic t_common;
    wrw(`PMC_DEV_VEND, `PMC_REG_COMMON, 16'h0000);
    chk("led", {15'h0, led}, 16'h0000);
    rdc(`PMC_DEV_VEND, `PMC_REG_COMMON, 16'h0000);
    wrw(`PMC_DEV_VEND, `PMC_REG_COMMON, 16'hffff);
    chk("led", {15'h0, led}, 16'h0001);
    rdc(`PMC_DEV_VEND, `PMC_REG_COMMON, 16'hffec);
    host.wrrd(`PMC_DEV_VEND, `PMC_REG_COMMON, 16'h5a4c);
    #1;
    chk("rvalid", {15'h0, rvalid}, 16'h0001);
    chk("rdata", rdata, 16'h5a44);
    chk("led", {15'h0, led}, 16'h0000);
    rdc(`PMC_DEV_PMA, `PMC_REG_FLP_LO, 16'h0000);
  endtask : t_common
  task automatic t_strap;
    @(posedge i_clock);
    strap <= 1'b0;
    i_srst <= 1'b1;
    repeat (3) @(posedge i_clock);
    i_srst <= 1'b0;
    #1;
    chk("led", {15'h0, led}, 16'h0000);
    chk("flp16", {15'h0, f16}, 16'h0000);
    chk("mismatch", {15'h0, mis}, 16'h0000);
    chk("lut", {13'h0, lut}, 16'h0004);
    rdc(`PMC_DEV_VEND, `PMC_REG_COMMON, 16'h0000);
    rdc(`PMC_DEV_PMA, `PMC_REG_LINK_UP, 16'h0108);
    rdc(`PMC_DEV_AN, `PMC_REG_FLP_LO, 16'h4000);
    rdc(`PMC_DEV_AN, `PMC_REG_FLP_HI, 16'h0003);
  endtask : t_strap
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_fail++;
      complete_run();
    end
  end
  initial begin
    repeat (5) @(posedge i_clock);
    i_srst <= 1'b0;
    t_reset();
    t_flp();
    t_link();
    t_common();
    t_strap();
    complete_run();
  end
endmodule : test_pmc_config_bank
